// *** iepr_pkg.sv ***
/*
 * package for the interrupt enable and priority-high register block:
 * register addresses, field positions, reset values and carrier types.
 * assumes an 8-bit special-function register space on the core side.
 */
`default_nettype none

package iepr_pkg;
    // special-function register addresses
    localparam logic [7:0] ADDR_ENABLE_LOW = 8'h00_a8;
    localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h00_b1;
    localparam logic [7:0] ADDR_PRIO_UPPER_SECOND = 8'h00_b3;
    localparam logic [7:0] ADDR_PRIO_UPPER_FIRST = 8'h00_b7;
    // reset values
    localparam logic [7:0] RESET_ENABLE = 8'h00_00;
    localparam logic [7:0] RESET_PRIO = 8'h00_00;
    // writable bit masks, reserved positions cleared
    localparam logic [7:0] MASK_ENABLE_LOW = 8'h00_df;
    localparam logic [7:0] MASK_ENABLE_HIGH = 8'h00_5f;
    localparam logic [7:0] MASK_PRIO_FIRST = 8'h00_7f;
    localparam logic [7:0] MASK_PRIO_SECOND = 8'h00_5f;
    // bit positions in the first enable register
    localparam int GLOBAL_IRQ_GATE_BIT = 7;
    // number of sources: low register 8 positions, high register 8 positions
    localparam int NUM_SOURCES = 16;
    // number of priority levels
    localparam int NUM_LEVELS = 4;
    localparam logic [2:0] LEVEL_IDLE = 3'h0_0;

    // register bus request bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } iepr_bus_req_t;

    // gated request with its level, toward the core's handler
    typedef struct packed {
        logic [NUM_SOURCES-1:0] gated;
        logic [2*NUM_SOURCES-1:0] level;
    } iepr_handler_t;
endpackage : iepr_pkg

`default_nettype wire

// *** iepr_regs.sv ***
/*
 * interrupt enable and priority-high registers with request gating,
 * level forming and pre-emption decision.
 * assumes requests and the lower priority bits arrive synchronous to clk_i,
 * and that the core pulses service_end_i when a service routine returns.
 * source index: 0..7 follow the first registers' bit positions (bit 5 =
 * decoder, bit 7 unused), 8..15 follow the second registers' positions.
 */
// Our own choice: strobed register access.
// Behaviour
// - global gate bit 7 masks all sources
// - first enable register at A8h, fixed layout
// - bit 6 gates the audio request
// - bit 1 gates the timer 0 request
// - reserved bit 5 reads zero
// - both enable registers reset to zero
// - second enable register at B1h, peripheral enables
// - bit 6 gates USB requests
// - bit 4 gates keyboard requests
// - bit 3 gates converter requests
// - bit 2 gates SPI requests
// - bit 1 gates two-wire requests
// - bit 0 gates memory-card requests
// - reserved bits 7 and 5 read zero
// - first priority-high register at B7h
// - bit 6 is audio level upper bit
// - bit 5 is decoder level upper bit
// - reserved bit 7 unset, reads zero
// - first priority-high resets bits 6..0 zero
// - second priority-high register at B3h
// - level is high bit and low bit
// - preempt only by strictly higher level
`timescale 1ns/1ps
`default_nettype none

module iepr_regs (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire iepr_pkg::iepr_bus_req_t bus_i, // register port
    output logic [7:0] rdata_o, // read data, cycle after strobe
    input wire logic [15:0] irq_req_i, // raw source requests
    input wire logic [15:0] prio_lower_i, // lower priority bits
    input wire logic service_end_i, // routine returned
    output logic [15:0] irq_gated_o, // enabled requests
    output logic [31:0] irq_level_o, // two-bit level per source
    output logic take_o, // a request may pre-empt now
    output logic [3:0] take_src_o, // which source to take
    output logic [1:0] take_level_o // its level
);
    // stored registers
    logic [7:0] enable_low;
    logic [7:0] enable_high;
    logic [7:0] prio_first;
    logic [7:0] prio_second;
    logic [7:0] next_enable_low;
    logic [7:0] next_enable_high;
    logic [7:0] next_prio_first;
    logic [7:0] next_prio_second;
    logic [7:0] next_rdata;
    // handler state
    logic [2:0] active_level; // 0 idle, else level+1 in service
    logic [2:0] next_active_level;
    logic [15:0] next_gated;
    logic [31:0] next_level;
    logic next_take;
    logic [3:0] next_take_src;
    logic [1:0] next_take_level;
    logic [7:0] srcs_en_lo;
    logic [7:0] srcs_en_hi;

    // register writes and readback
    always_comb begin
        next_enable_low = enable_low;
        next_enable_high = enable_high;
        next_prio_first = prio_first;
        next_prio_second = prio_second;
        next_rdata = 8'h00_00;
        if (bus_i.wr) begin
            case (bus_i.addr)
                iepr_pkg::ADDR_ENABLE_LOW: begin
                    next_enable_low = bus_i.wdata & iepr_pkg::MASK_ENABLE_LOW;
                end
                iepr_pkg::ADDR_ENABLE_HIGH: begin
                    next_enable_high = bus_i.wdata & iepr_pkg::MASK_ENABLE_HIGH;
                end
                iepr_pkg::ADDR_PRIO_UPPER_FIRST: begin
                    next_prio_first = bus_i.wdata & iepr_pkg::MASK_PRIO_FIRST;
                end
                iepr_pkg::ADDR_PRIO_UPPER_SECOND: begin
                    next_prio_second = bus_i.wdata & iepr_pkg::MASK_PRIO_SECOND;
                end
                default: begin // unmapped: ignored
                end
            endcase
        end
        if (bus_i.rd) begin
            case (bus_i.addr)
                iepr_pkg::ADDR_ENABLE_LOW: next_rdata = enable_low;
                iepr_pkg::ADDR_ENABLE_HIGH: next_rdata = enable_high;
                iepr_pkg::ADDR_PRIO_UPPER_FIRST: next_rdata = prio_first;
                iepr_pkg::ADDR_PRIO_UPPER_SECOND: next_rdata = prio_second;
                default: next_rdata = 8'h00_00; // unmapped reads zero
            endcase
        end
    end

    // register storage
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            enable_low <= iepr_pkg::RESET_ENABLE;
            enable_high <= iepr_pkg::RESET_ENABLE;
            prio_first <= iepr_pkg::RESET_PRIO;
            prio_second <= iepr_pkg::RESET_PRIO;
            rdata_o <= 8'h00_00;
        end else begin
            enable_low <= next_enable_low;
            enable_high <= next_enable_high;
            prio_first <= next_prio_first;
            prio_second <= next_prio_second;
            rdata_o <= next_rdata;
        end
    end

    // gating, level forming and pick of the best pending source
    always_comb begin
        logic [1:0] lvl;
        logic found;
        lvl = 2'h0;
        found = 1'b0;
        // global gate masks all; otherwise each own bit gates
        srcs_en_lo = enable_low[iepr_pkg::GLOBAL_IRQ_GATE_BIT]
            ? {1'b0, enable_low[6:0]} : 8'h00_00;
        // decoder source at index 5 has no own enable here, rides the gate
        srcs_en_lo[5] = enable_low[iepr_pkg::GLOBAL_IRQ_GATE_BIT];
        srcs_en_hi = enable_low[iepr_pkg::GLOBAL_IRQ_GATE_BIT]
            ? enable_high : 8'h00_00;
        next_gated = irq_req_i & {srcs_en_hi, srcs_en_lo};
        // upper bit from priority-high, lower from outside
        for (int i = 0; i < 8; i++) begin
            next_level[2*i +: 2] = {prio_first[i], prio_lower_i[i]};
            next_level[2*(i+8) +: 2] = {prio_second[i], prio_lower_i[i+8]};
        end
        // highest level first, lowest index within a level
        next_take = 1'b0;
        next_take_src = 4'h0;
        next_take_level = 2'h0;
        for (int l = iepr_pkg::NUM_LEVELS - 1; l >= 0; l--) begin
            for (int i = 0; i < iepr_pkg::NUM_SOURCES; i++) begin
                if (!found && next_gated[i] && next_level[2*i +: 2] == l[1:0]) begin
                    found = 1'b1;
                    lvl = l[1:0];
                    next_take_src = i[3:0];
                end
            end
        end
        // strictly higher than the level in service
        if (found && ({1'b0, lvl} + 3'h1 > active_level)) begin
            next_take = 1'b1;
            next_take_level = lvl;
        end
        next_active_level = active_level;
        if (take_o) begin
            next_active_level = {1'b0, take_level_o} + 3'h1;
        end else if (service_end_i) begin
            next_active_level = iepr_pkg::LEVEL_IDLE;
        end
    end

    // handler-facing registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_gated_o <= 16'h0000;
            irq_level_o <= 32'h0000_0000;
            take_o <= 1'b0;
            take_src_o <= 4'h0;
            take_level_o <= 2'h0;
            active_level <= iepr_pkg::LEVEL_IDLE;
        end else begin
            irq_gated_o <= next_gated;
            irq_level_o <= next_level;
            take_o <= next_take && !take_o;
            take_src_o <= next_take_src;
            take_level_o <= next_take_level;
            active_level <= next_active_level;
        end
    end

    // global gate cleared blocks every source
    a_gate_masks_all: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !enable_low[7] |=> irq_gated_o == 16'h0000)
        else $error("source passed with global gate clear");
    // audio passes when enabled
    a_audio_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_req_i[6] && enable_low[7] && enable_low[6] |=> irq_gated_o[6])
        else $error("audio request blocked while enabled");
    a_timer0_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_req_i[1] && !enable_low[1] |=> !irq_gated_o[1])
        else $error("timer 0 request passed while disabled");
    a_usb_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_req_i[14] && enable_low[7] && enable_high[6] |=> irq_gated_o[14])
        else $error("usb request blocked while enabled");
    // reserved positions read zero
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        bus_i.rd && bus_i.addr == 8'h00_a8 |=> rdata_o[5] == 1'b0)
        else $error("reserved enable bit read as one");
    a_high_reserved: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        bus_i.rd && bus_i.addr == 8'h00_b1 |=> rdata_o[7] == 1'b0 && rdata_o[5] == 1'b0)
        else $error("reserved high enable bit read as one");
    // write then read returns the byte with bit 7 masked off
    a_write_back: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        bus_i.wr && bus_i.addr == 8'h00_b7 ##1 bus_i.rd && bus_i.addr == 8'h00_b7
        |=> rdata_o == ($past(bus_i.wdata, 2) & 8'h00_7f))
        else $error("priority byte not returned");
    // level formed from both bits
    a_level_form: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        1'b1 |=> irq_level_o[13:12] == {$past(prio_first[6]), $past(prio_lower_i[6])})
        else $error("audio level mismatched");
    // no take at or below the level in service
    a_no_equal_preempt: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        take_o |-> {1'b0, take_level_o} >= $past(active_level))
        else $error("pre-empted by equal or lower level");

    // read data stands one cycle only, zero otherwise
    a_rdata_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !bus_i.rd
        |=> rdata_o == 8'h00_00)
        else $error("read data seen without a read strobe");

    // first enable write lands masked
    a_low_write_lands: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        bus_i.wr && bus_i.addr == iepr_pkg::ADDR_ENABLE_LOW
        |=> enable_low == ($past(bus_i.wdata) & iepr_pkg::MASK_ENABLE_LOW))
        else $error("first enable write not stored");

    // second enable write lands masked
    a_high_write_lands: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        bus_i.wr && bus_i.addr == iepr_pkg::ADDR_ENABLE_HIGH
        |=> enable_high == ($past(bus_i.wdata) & iepr_pkg::MASK_ENABLE_HIGH))
        else $error("second enable write not stored");

    // first priority-high write lands masked
    a_prio_first_lands: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        bus_i.wr && bus_i.addr == iepr_pkg::ADDR_PRIO_UPPER_FIRST
        |=> prio_first == ($past(bus_i.wdata) & iepr_pkg::MASK_PRIO_FIRST))
        else $error("first priority write not stored");

    // second priority-high write lands masked
    a_prio_second_lands: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        bus_i.wr && bus_i.addr == iepr_pkg::ADDR_PRIO_UPPER_SECOND
        |=> prio_second == ($past(bus_i.wdata) & iepr_pkg::MASK_PRIO_SECOND))
        else $error("second priority write not stored");

    // first enable keeps its value unless written
    a_low_holds: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(bus_i.wr && bus_i.addr == iepr_pkg::ADDR_ENABLE_LOW)
        |=> $stable(enable_low))
        else $error("first enable changed without a write");

    // second enable keeps its value unless written
    a_high_holds: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(bus_i.wr && bus_i.addr == iepr_pkg::ADDR_ENABLE_HIGH)
        |=> $stable(enable_high))
        else $error("second enable changed without a write");

    // reserved first enable position never stored
    a_low_reserved_store: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        1'b1
        |-> enable_low[5] == 1'b0)
        else $error("reserved first enable bit stored as one");

    // reserved second enable positions never stored
    a_high_reserved_store: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        1'b1
        |-> enable_high[7] == 1'b0 && enable_high[5] == 1'b0)
        else $error("reserved second enable bit stored as one");

    // reserved top priority bit never stored
    a_prio_top_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        1'b1
        |-> prio_first[7] == 1'b0)
        else $error("reserved priority bit stored as one");

    // reserved top priority bit reads zero
    a_prio_top_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        bus_i.rd && bus_i.addr == iepr_pkg::ADDR_PRIO_UPPER_FIRST
        |=> rdata_o[7] == 1'b0)
        else $error("reserved priority bit read as one");

    // keyboard blocked while its enable is clear
    a_keypad_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_req_i[12] && !enable_high[4]
        |=> !irq_gated_o[12])
        else $error("keyboard request passed while disabled");

    // converter blocked while its enable is clear
    a_converter_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_req_i[11] && !enable_high[3]
        |=> !irq_gated_o[11])
        else $error("converter request passed while disabled");

    // spi blocked while its enable is clear
    a_spi_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_req_i[10] && !enable_high[2]
        |=> !irq_gated_o[10])
        else $error("spi request passed while disabled");

    // two-wire blocked while its enable is clear
    a_two_wire_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_req_i[9] && !enable_high[1]
        |=> !irq_gated_o[9])
        else $error("two-wire request passed while disabled");

    // memory card blocked while its enable is clear
    a_card_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_req_i[8] && !enable_high[0]
        |=> !irq_gated_o[8])
        else $error("card request passed while disabled");

    // usb blocked while its enable is clear
    a_usb_block: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_req_i[14] && !enable_high[6]
        |=> !irq_gated_o[14])
        else $error("usb request passed while disabled");

    // audio blocked while its enable is clear
    a_audio_block: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_req_i[6] && !enable_low[6]
        |=> !irq_gated_o[6])
        else $error("audio request passed while disabled");

    // timer 0 passes while enabled
    a_timer0_pass: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        irq_req_i[1] && enable_low[7] && enable_low[1]
        |=> irq_gated_o[1])
        else $error("timer 0 request blocked while enabled");

    // decoder level from its two bits
    a_decoder_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        1'b1
        |=> irq_level_o[11:10] == {$past(prio_first[5]), $past(prio_lower_i[5])})
        else $error("decoder level mismatched");

    // usb level from the second priority register
    a_usb_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        1'b1
        |=> irq_level_o[29:28] == {$past(prio_second[6]), $past(prio_lower_i[14])})
        else $error("usb level mismatched");

    // a take is a single-cycle pulse
    a_take_single: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        take_o
        |=> !take_o)
        else $error("take held for two cycles");

    // a take names a source that is pending and enabled
    a_take_needs_req: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        take_o
        |-> irq_gated_o[take_src_o])
        else $error("take of a source not pending");

    // a take reports the level of its source
    a_take_level_match: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        take_o
        |-> irq_level_o[2*take_src_o +: 2] == take_level_o)
        else $error("take level differs from source level");

    // routine return with no take drops to idle
    a_service_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        service_end_i && !take_o
        |=> active_level == iepr_pkg::LEVEL_IDLE)
        else $error("service level kept after return");

    // a take enters its level into service
    a_take_enters: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        take_o
        |=> active_level == {1'b0, $past(take_level_o)} + 3'h1)
        else $error("taken level not entered into service");
endmodule : iepr_regs

`default_nettype wire

// *** iepr_src_model.sv ***
/*
 * far side model: peripheral request sources and the core's handler.
 * assumes the bench sets the wanted request pattern and may stall returns.
 */
`timescale 1ns/1ps
`default_nettype none

module iepr_src_model (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] req_set_i, // pattern the bench wants raised
    input wire logic take_i, // handler accepted a request
    input wire logic hold_i, // routine runs on while high
    output logic [15:0] irq_req_o, // request levels toward the block
    output logic service_end_o // routine return pulse
);
    logic [2:0] busy_cnt; // cycles left in the routine

    // requests follow the bench; a routine returns four cycles after a take
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_req_o <= 16'h0000;
            busy_cnt <= 3'h0;
            service_end_o <= 1'h0;
        end else begin
            irq_req_o <= req_set_i;
            service_end_o <= (busy_cnt == 3'h1) && !hold_i;
            if (take_i) begin
                busy_cnt <= 3'h4;
            end else if (busy_cnt > 3'h1 || (busy_cnt == 3'h1 && !hold_i)) begin
                busy_cnt <= busy_cnt - 3'h1;
            end
        end
    end
endmodule : iepr_src_model

`default_nettype wire

// *** irq_enable_priority_regs_tb.sv ***
/*
 * self-checking bench for the enable and priority-high registers.
 * assumes the register port timing and handler contract of the design.
 */
`timescale 1ns/1ps
`default_nettype none

module irq_enable_priority_regs_tb;
    localparam logic [7:0] A_LO = iepr_pkg::ADDR_ENABLE_LOW;
    localparam logic [7:0] A_HI = iepr_pkg::ADDR_ENABLE_HIGH;
    localparam logic [7:0] A_P1 = iepr_pkg::ADDR_PRIO_UPPER_FIRST;
    localparam logic [7:0] A_P2 = iepr_pkg::ADDR_PRIO_UPPER_SECOND;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    iepr_pkg::iepr_bus_req_t bus = '0; // register port
    logic [7:0] rdata;
    logic [15:0] req_set = 16'h0000; // wanted requests
    logic [15:0] irq_req;
    logic [15:0] prio_lower = 16'h0000; // lower level bits
    logic [15:0] gated;
    logic [31:0] level;
    logic service_end;
    logic take;
    logic hold = 1'h0; // stall routine return
    logic [3:0] take_src;
    logic [1:0] take_level;
    int n_fail = 0;
    int comparisons = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    iepr_regs dut (.clk_i(clk), .reset_n_i(reset_n), .bus_i(bus), .rdata_o(rdata),
        .irq_req_i(irq_req), .prio_lower_i(prio_lower), .service_end_i(service_end),
        .irq_gated_o(gated), .irq_level_o(level), .take_o(take), .take_src_o(take_src),
        .take_level_o(take_level));
    iepr_src_model partner (.clk_i(clk), .reset_n_i(reset_n), .req_set_i(req_set),
        .take_i(take), .hold_i(hold), .irq_req_o(irq_req), .service_end_o(service_end));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'h1;
        @(posedge clk);
        bus.wr <= 1'h0;
    endtask : wr

    // read data sampled in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'h1;
        @(posedge clk);
        bus.rd <= 1'h0;
        @(negedge clk);
        check("rdata", {24'h0000_00, exp}, {24'h0000_00, rdata});
    endtask : rd_chk

    // write then read back with no idle cycle between the strobes
    task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'h1;
        @(posedge clk);
        bus.wr <= 1'h0;
        bus.rd <= 1'h1;
        @(posedge clk);
        bus.rd <= 1'h0;
        @(negedge clk);
        check("rdata", {24'h0000_00, exp}, {24'h0000_00, rdata});
    endtask : wr_rd_chk

    // bounded wait for a take pulse, then its source and level
    task automatic wait_take(input logic [3:0] src, input logic [1:0] lvl);
        int n = 0;
        while (take !== 1'h1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("take", 32'h0000_0001, {31'h0000_0000, take});
        check("take_src", {28'h000_0000, src}, {28'h000_0000, take_src});
        check("take_level", {30'h0000_0000, lvl}, {30'h0000_0000, take_level});
        @(negedge clk);
    endtask : wait_take

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude

    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        n_fail++;
        conclude();
    end

    initial begin
        logic [7:0] en;
        int seen;
        repeat (8) @(posedge clk);
        reset_n <= 1'h1;
        rd_chk(A_LO, 8'h00);
        rd_chk(A_HI, 8'h00);
        rd_chk(A_P1, 8'h00);
        $display("test reset_values done");
        // all ones written, reserved positions must drop
        wr(A_LO, 8'hff);
        rd_chk(A_LO, 8'hdf);
        wr(A_HI, 8'hff);
        rd_chk(A_HI, 8'h5f);
        wr_rd_chk(A_P1, 8'hff, 8'h7f);
        wr(A_P2, 8'hff);
        rd_chk(A_P2, 8'h5f);
        rd_chk(8'ha9, 8'h00);
        wr(A_LO, 8'h00);
        wr(A_HI, 8'h00);
        wr(A_P1, 8'h00);
        wr(A_P2, 8'h00);
        $display("test register_access done");
        // every source with its own enable bit alone through it, then global gate off
        req_set <= 16'hffdf;
        for (int i = 0; i < 16; i++) begin
            if (i == 5 || i == 7 || i == 13 || i == 15) continue;
            en = 8'h01 << (i % 8);
            wr(A_LO, i < 8 ? 8'h80 | en : 8'h80);
            wr(A_HI, i < 8 ? 8'h00 : en);
            repeat (2) @(negedge clk);
            check("gated", 32'h0000_0001 << i, {16'h0000, gated});
            wr(A_LO, i < 8 ? en : 8'h00);
            repeat (2) @(negedge clk);
            check("gated", 32'h0000_0000, {16'h0000, gated});
        end
        $display("test gating done");
        // levels: audio upper and lower set, decoder upper only
        req_set <= 16'h0000;
        hold <= 1'h1;
        prio_lower <= 16'h0040;
        wr(A_P1, 8'h60);
        wr(A_LO, 8'hc3);
        repeat (2) @(negedge clk);
        check("level", 32'h0000_3800, level);
        // level 0 taken, equal level refused, level 3 pre-empts
        req_set <= 16'h0002;
        wait_take(4'h1, 2'h0);
        req_set <= 16'h0003;
        seen = 0;
        repeat (8) begin
            @(negedge clk);
            if (take === 1'h1) seen++;
        end
        check("equal_take", 32'h0000_0000, seen);
        req_set <= 16'h0043;
        wait_take(4'h6, 2'h3);
        // routine returns: level in service drops, pending audio taken again
        hold <= 1'h0;
        wait_take(4'h6, 2'h3);
        $display("test preemption done");
        conclude();
    end
endmodule : irq_enable_priority_regs_tb

`default_nettype wire
